/* File: hdl/rts_pkg.sv */
// Constants for the reset and start-up timeout sequencer.
// Assumes a 20 MHz system clock; the core consumes the reset outputs.
package rts_pkg;

    localparam int CLK_NS = 50;

    // Start-up timing
    localparam int CORE_START_NS  = 10000;
    localparam int CORE_START_CYC = (CORE_START_NS + CLK_NS - 1) / CLK_NS;
    localparam int FILT_NS        = 300;
    localparam int FILT_CYC       = (FILT_NS + CLK_NS - 1) / CLK_NS;
    localparam int POWERUP_DELAY_TIMER_MS        = 72;
    localparam int SLOW_OSC_HZ    = 31250;
    localparam int POWERUP_DELAY_TIMER_TICKS     = POWERUP_DELAY_TIMER_MS * SLOW_OSC_HZ / 1000;
    localparam int OST_CYCLES     = 1024;

    // Register offsets
    localparam logic [7:0] ADDR_CFG     = 8'h00;
    localparam logic [7:0] ADDR_STAT    = 8'h04;
    localparam logic [7:0] ADDR_IRQ_ST  = 8'h08;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_EN  = 8'h10;

    // Configuration register fields
    localparam int CFG_POWERUP_DELAY_TIMER_EN_N = 0;
    localparam int CFG_BOR_EN    = 1;
    localparam int CFG_PIN_SEL   = 2;
    localparam int CFG_OSC_LSB   = 3;
    localparam logic [5:0] CFG_RESET = 6'h07;

    // Status register fields
    localparam int ST_TO_N   = 0;
    localparam int ST_PD_N   = 1;
    localparam int ST_POR_N  = 2;
    localparam int ST_CAUSE  = 3;
    localparam int ST_HOLD   = 6;
    localparam int ST_REGRST = 7;

    // Oscillator modes
    localparam logic [2:0] OSC_LP = 3'h0;
    localparam logic [2:0] OSC_XT = 3'h1;
    localparam logic [2:0] OSC_HS = 3'h2;

    // Reset causes; also the interrupt bit index
    localparam logic [2:0] CAUSE_POR      = 3'h0;
    localparam logic [2:0] CAUSE_PIN_RUN  = 3'h1;
    localparam logic [2:0] CAUSE_PIN_SLP  = 3'h2;
    localparam logic [2:0] CAUSE_WDT_RST  = 3'h3;
    localparam logic [2:0] CAUSE_WDT_WAKE = 3'h4;
    localparam logic [2:0] CAUSE_BOR      = 3'h5;
    localparam int IRQ_RELEASE = 6;
    localparam int IRQ_W       = 7;

    typedef enum logic [2:0] {
        ST_RUN, ST_SRC, ST_POWERUP_DELAY_TIMER, ST_OST, ST_WAIT
    } rts_state_type;

endpackage

/* File: hdl/rts_sequencer.sv */
// Reset source merging and start-up timeout sequencer.
// Assumes pins and slow oscillator are asynchronous; watchdog and
// sleep signals come from logic on clk_sys.
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module rts_sequencer
    import rts_pkg::*;
#(
    parameter logic [11:0] POWERUP_DELAY_TIMER_CNT = 12'(POWERUP_DELAY_TIMER_TICKS),
    parameter logic [11:0] OST_CNT  = 12'(OST_CYCLES)
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       por_detect,
    input  wire logic       brownout_detect,
    input  wire logic       ext_reset_n,
    input  wire logic       internal_slow_osc,
    input  wire logic       osc_input_pin,
    input  wire logic       watchdog,
    input  wire logic       core_asleep,
    input  wire logic [7:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic       wr_stb,
    input  wire logic       rd_stb,
    output logic [31:0]     rdata_q,
    output logic            core_hold_q,
    output logic            regs_reset_q,
    output logic            timeout_flag_n_q,
    output logic            powerdown_flag_n_q,
    output logic            shared_port_input_q,
    output logic            irq_q
);

    // Pin bit order: pin, osc, slow osc, por, brown-out
    localparam logic [4:0] SYNC_RST = 5'h01;

    logic [4:0]    s1_q, s2_q, s3_q, pin_q, pin_d;
    logic [5:0]    cfg_q, cfg_d;
    logic [2:0]    filt_cnt_q, filt_cnt_d;
    logic          filt_low_q, filt_low_d;
    rts_state_type state_q, state_d;
    logic [11:0]   cnt_q, cnt_d;
    logic [7:0]    core_cnt_q, core_cnt_d;
    logic          por_kind_q, por_kind_d;
    logic          wake_q, wake_d;
    logic [2:0]    cause_q, cause_d;
    logic          to_n_d, pd_n_d, por_n_q, por_n_d;
    logic          hold_d, regrst_d;
    logic [IRQ_W-1:0] ist_q, ist_d, ien_q, ien_d, ev;
    logic          irq_d, port_d;
    logic [31:0]   rdata_d;
    logic          por_s, bor_act, ext_act, ext_q, ext_ev;
    logic          slow_rise, osc_rise, crystal, need_ost;

    function automatic logic is_crystal(input logic [2:0] m);
        return (m == OSC_LP) || (m == OSC_XT) || (m == OSC_HS);
    endfunction

    // Pin synchronisers; a change counts once stages two and three agree
    always_comb begin
        pin_d = pin_q;
        for (int i = 0; i < 5; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                pin_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s1_q  <= SYNC_RST;
            s2_q  <= SYNC_RST;
            s3_q  <= SYNC_RST;
            pin_q <= SYNC_RST;
        end else begin
            s1_q  <= {brownout_detect, por_detect, internal_slow_osc,
                      osc_input_pin, ext_reset_n};
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            pin_q <= pin_d;
        end
    end

    assign slow_rise = pin_d[2] & ~pin_q[2];
    assign osc_rise  = pin_d[1] & ~pin_q[1];
    assign por_s     = pin_q[3];
    // Brown-out is gated only by its own enable
    assign bor_act   = pin_q[4] & cfg_q[CFG_BOR_EN];
    assign crystal   = is_crystal(cfg_q[CFG_OSC_LSB +: 3]);

    // Glitch filter: level must stand FILT_CYC cycles to count
    always_comb begin
        filt_low_d = filt_low_q;
        filt_cnt_d = '0;
        if (~pin_q[0] != filt_low_q) begin
            filt_cnt_d = filt_cnt_q + 3'h1;
            if (filt_cnt_q == 3'(FILT_CYC - 1)) begin
                filt_low_d = ~pin_q[0];
                filt_cnt_d = '0;
            end
        end
    end

    // Input mode masks the external pin reset
    assign ext_act = filt_low_q & cfg_q[CFG_PIN_SEL];
    assign ext_ev  = ext_act & ~ext_q;
    assign port_d  = cfg_q[CFG_PIN_SEL] ? 1'b0 : pin_q[0];

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            filt_low_q <= 1'b0;
            filt_cnt_q <= '0;
            ext_q      <= 1'b0;
            shared_port_input_q <= 1'b0;
        end else begin
            filt_low_q <= filt_low_d;
            filt_cnt_q <= filt_cnt_d;
            ext_q      <= ext_act;
            shared_port_input_q <= port_d;
        end
    end

    // Sequencer
    always_comb begin
        state_d    = state_q;
        cnt_d      = cnt_q;
        core_cnt_d = (core_cnt_q != 8'h00) ? core_cnt_q - 8'h01 : 8'h00;
        por_kind_d = por_kind_q;
        wake_d     = wake_q;
        cause_d    = cause_q;
        to_n_d     = timeout_flag_n_q;
        pd_n_d     = powerdown_flag_n_q;
        por_n_d    = por_n_q;
        ev         = '0;
        need_ost   = crystal & (por_kind_q | wake_q);
        case (state_q)
            ST_RUN: begin
                if (ext_ev) begin
                    state_d = ST_WAIT;
                    wake_d  = 1'b0;
                    if (core_asleep) begin
                        cause_d = CAUSE_PIN_SLP;
                        to_n_d  = 1'b1;
                        pd_n_d  = 1'b0;
                    end else begin
                        cause_d = CAUSE_PIN_RUN;
                    end
                end else if (watchdog) begin
                    // Internal only; the pin has no driver here
                    to_n_d  = 1'b0;
                    if (core_asleep) begin
                        cause_d    = CAUSE_WDT_WAKE;
                        pd_n_d     = 1'b0;
                        wake_d     = 1'b1;
                        por_kind_d = 1'b0;
                        core_cnt_d = 8'(CORE_START_CYC);
                        state_d    = crystal ? ST_OST : ST_WAIT;
                    end else begin
                        cause_d = CAUSE_WDT_RST;
                        pd_n_d  = 1'b1;
                        wake_d  = 1'b0;
                        state_d = ST_WAIT;
                    end
                end
            end
            ST_SRC: begin
                core_cnt_d = 8'(CORE_START_CYC);
                if (!por_s && !bor_act) begin
                    if (!cfg_q[CFG_POWERUP_DELAY_TIMER_EN_N]) begin
                        state_d = ST_POWERUP_DELAY_TIMER;
                    end else if (need_ost) begin
                        state_d = ST_OST;
                    end else begin
                        state_d = ST_WAIT;
                    end
                end
            end
            ST_POWERUP_DELAY_TIMER: begin
                if (slow_rise) begin
                    cnt_d = cnt_q + 12'h001;
                    if (cnt_q == POWERUP_DELAY_TIMER_CNT - 12'h001) begin
                        state_d = need_ost ? ST_OST : ST_WAIT;
                    end
                end
            end
            ST_OST: begin
                if (osc_rise) begin
                    cnt_d = cnt_q + 12'h001;
                    if (cnt_q == OST_CNT - 12'h001) begin
                        state_d = ST_WAIT;
                    end
                end
            end
            default: begin
                // Pin low past all delays: release on its rise
                if (core_cnt_q == 8'h00 && !ext_act) begin
                    state_d = ST_RUN;
                    ev[IRQ_RELEASE] = 1'b1;
                end
            end
        endcase
        // Power-on and brown-out restart the whole sequence
        if (por_s || bor_act) begin
            state_d = ST_SRC;
            wake_d  = 1'b0;
            if (por_s) begin
                por_kind_d = 1'b1;
                cause_d    = CAUSE_POR;
                por_n_d    = 1'b0;
            end else if (state_q != ST_SRC || cause_q != CAUSE_POR) begin
                por_kind_d = 1'b0;
                cause_d    = CAUSE_BOR;
            end
            to_n_d = 1'b1;
            pd_n_d = 1'b1;
        end
        if (state_d != state_q) begin
            cnt_d = '0;
            if (state_q == ST_RUN || state_d == ST_SRC) begin
                ev[cause_d] = 1'b1;
            end
        end
        // A power-on in the same cycle wins over the software set
        if (wr_stb && addr == ADDR_STAT && wdata[ST_POR_N] && !por_s) begin
            por_n_d = 1'b1;
        end
        hold_d   = (state_d != ST_RUN);
        // Retained class has no reset line at all
        regrst_d = hold_d & ~wake_d;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q            <= ST_SRC;
            cnt_q              <= '0;
            core_cnt_q         <= '0;
            por_kind_q         <= 1'b1;
            wake_q             <= 1'b0;
            cause_q            <= CAUSE_POR;
            timeout_flag_n_q   <= 1'b1;
            powerdown_flag_n_q <= 1'b1;
            por_n_q            <= 1'b0;
            core_hold_q        <= 1'b1;
            regs_reset_q       <= 1'b1;
        end else begin
            state_q            <= state_d;
            cnt_q              <= cnt_d;
            core_cnt_q         <= core_cnt_d;
            por_kind_q         <= por_kind_d;
            wake_q             <= wake_d;
            cause_q            <= cause_d;
            timeout_flag_n_q   <= to_n_d;
            powerdown_flag_n_q <= pd_n_d;
            por_n_q            <= por_n_d;
            core_hold_q        <= hold_d;
            regs_reset_q       <= regrst_d;
        end
    end

    // Register bus and interrupt; set wins over clear
    always_comb begin
        cfg_d   = cfg_q;
        ien_d   = ien_q;
        ist_d   = ist_q;
        rdata_d = '0;
        if (wr_stb && addr == ADDR_CFG) begin
            cfg_d = wdata[5:0];
        end else if (wr_stb && addr == ADDR_IRQ_EN) begin
            ien_d = wdata[IRQ_W-1:0];
        end else if (wr_stb && addr == ADDR_IRQ_CLR) begin
            ist_d = ist_q & ~wdata[IRQ_W-1:0];
        end
        ist_d = ist_d | ev;
        irq_d = |(ist_d & ien_d);
        if (rd_stb && addr == ADDR_CFG) begin
            rdata_d[5:0] = cfg_q;
        end else if (rd_stb && addr == ADDR_STAT) begin
            rdata_d[ST_TO_N]     = timeout_flag_n_q;
            rdata_d[ST_PD_N]     = powerdown_flag_n_q;
            rdata_d[ST_POR_N]    = por_n_q;
            rdata_d[ST_CAUSE+:3] = cause_q;
            rdata_d[ST_HOLD]     = core_hold_q;
            rdata_d[ST_REGRST]   = regs_reset_q;
        end else if (rd_stb && addr == ADDR_IRQ_ST) begin
            rdata_d[IRQ_W-1:0] = ist_q;
        end else if (rd_stb && addr == ADDR_IRQ_EN) begin
            rdata_d[IRQ_W-1:0] = ien_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg_q   <= CFG_RESET;
            ien_q   <= '0;
            ist_q   <= '0;
            irq_q   <= 1'b0;
            rdata_q <= '0;
        end else begin
            cfg_q   <= cfg_d;
            ien_q   <= ien_d;
            ist_q   <= ist_d;
            irq_q   <= irq_d;
            rdata_q <= rdata_d;
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    AST_POR_FLAGS: assert property (por_s |=>
        timeout_flag_n_q && powerdown_flag_n_q && !por_n_q)
        else $error("power-on flags wrong");
    AST_WAKE_FLAGS: assert property (state_q == ST_RUN && !ext_ev &&
        watchdog && core_asleep && !por_s && !bor_act |=>
        !timeout_flag_n_q && !powerdown_flag_n_q && !regs_reset_q)
        else $error("watchdog wake handled wrong");
    AST_RELEASE: assert property ($fell(core_hold_q) |->
        $past(state_q) == ST_WAIT && $past(core_cnt_q) == 8'h00 &&
        !$past(ext_act)) else $error("early release");
    AST_POWERUP_DELAY_TIMER_EN: assert property (state_q == ST_SRC &&
        state_d == ST_POWERUP_DELAY_TIMER |-> !cfg_q[CFG_POWERUP_DELAY_TIMER_EN_N])
        else $error("power-up delay ran while disabled");
    AST_OST_MODE: assert property ($rose(state_q == ST_OST) |->
        $past(crystal)) else $error("start-up count in wrong mode");
    AST_PIN_MASK: assert property (!cfg_q[CFG_PIN_SEL] |->
        !ext_act) else $error("reset from pin in input mode");
    AST_FILTER: assert property ($rose(filt_low_q) |->
        $past(!pin_q[0], 1) && $past(!pin_q[0], 2) &&
        $past(!pin_q[0], 3)) else $error("glitch passed filter");
    AST_POR_N: assert property ($fell(por_n_q) |->
        $past(por_s)) else $error("power-on flag cleared wrongly");
    AST_CORE_WAIT: assert property ($rose(core_cnt_q == 8'(CORE_START_CYC))
        |-> core_hold_q [*8]) else $error("core start-up cut short");

    COV_WAKE: cover property (cause_q == CAUSE_WDT_WAKE ##1 !core_hold_q);
    COV_PIN: cover property (cause_q == CAUSE_PIN_RUN ##1 $fell(core_hold_q));
    COV_OST: cover property ($fell(state_q == ST_OST));

endmodule // rts_sequencer

`default_nettype wire

/* File: testbench/rts_partner.sv */
// Model of the reset sources and clocks around the sequencer.
// Assumes the bench calls its tasks; clk_sys-domain drives follow rising edges.
`timescale 1ns/1ps
`default_nettype none

module rts_partner (
    input  wire logic clk_sys,
    output var logic  por_detect,
    output var logic  brownout_detect,
    output var logic  ext_reset_n,
    output var logic  internal_slow_osc,
    output var logic  osc_input_pin,
    output var logic  watchdog,
    output var logic  core_asleep
);
    initial begin
        por_detect = 1'b0;
        brownout_detect = 1'b0;
        ext_reset_n = 1'b1;
        internal_slow_osc = 1'b0;
        osc_input_pin = 1'b0;
        watchdog = 1'b0;
        core_asleep = 1'b0;
    end

    // Free-running, slow enough for the sampled edge counters
    always #1000 internal_slow_osc = ~internal_slow_osc;
    always #150 osc_input_pin = ~osc_input_pin;

    // Source 0 power-on, 1 brown-out, 2 pin, else watchdog
    task automatic hold_line(input int sel, input int n);
        @(posedge clk_sys);
        case (sel)
            0: por_detect <= 1'b1;
            1: brownout_detect <= 1'b1;
            2: ext_reset_n <= 1'b0;
            default: watchdog <= 1'b1;
        endcase
        repeat (n) @(posedge clk_sys);
        por_detect <= 1'b0;
        brownout_detect <= 1'b0;
        ext_reset_n <= 1'b1; // Pull-up restores the pin
        watchdog <= 1'b0;
    endtask

    task automatic set_sleep(input logic s);
        @(posedge clk_sys);
        core_asleep <= s;
    endtask
endmodule // rts_partner

`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking bench for the reset and start-up timeout sequencer.
// Assumes shortened delay counts; the partner model supplies all sources.
`timescale 1ns/1ps
`default_nettype none

module tb;
    import rts_pkg::*;
    localparam logic [11:0] POWERUP_DELAY_TIMER_SMALL = 12'h008;
    localparam logic [11:0] OST_SMALL  = 12'h040;
    localparam int          SLOW_CYC   = 40;
    localparam int          OSC_CYC    = 6;
    localparam int          POWERUP_DELAY_TIMER_MIN   = (int'(POWERUP_DELAY_TIMER_SMALL) - 1) * SLOW_CYC;
    localparam int          OST_MIN    = (int'(OST_SMALL) - 1) * OSC_CYC;

    logic        clk_sys, rst, wr_stb, rd_stb;
    logic        por_detect, brownout_detect, ext_reset_n, watchdog;
    logic        internal_slow_osc, osc_input_pin, core_asleep;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata_q, v;
    logic        core_hold_q, regs_reset_q, timeout_flag_n_q;
    logic        powerdown_flag_n_q, shared_port_input_q, irq_q;
    int          n_mismatch, n_tests, cnt;
    bit          hit;

    rts_sequencer #(.POWERUP_DELAY_TIMER_CNT(POWERUP_DELAY_TIMER_SMALL), .OST_CNT(OST_SMALL)) rts_sequencer_i (
        .clk_sys(clk_sys), .rst(rst), .por_detect(por_detect),
        .brownout_detect(brownout_detect), .ext_reset_n(ext_reset_n),
        .internal_slow_osc(internal_slow_osc), .osc_input_pin(osc_input_pin),
        .watchdog(watchdog), .core_asleep(core_asleep), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_q(rdata_q), .core_hold_q(core_hold_q),
        .regs_reset_q(regs_reset_q), .timeout_flag_n_q(timeout_flag_n_q),
        .powerdown_flag_n_q(powerdown_flag_n_q),
        .shared_port_input_q(shared_port_input_q), .irq_q(irq_q));

    rts_partner rts_partner_i (
        .clk_sys(clk_sys), .por_detect(por_detect), .brownout_detect(brownout_detect),
        .ext_reset_n(ext_reset_n), .internal_slow_osc(internal_slow_osc),
        .osc_input_pin(osc_input_pin), .watchdog(watchdog), .core_asleep(core_asleep));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wr_stb <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        @(posedge clk_sys);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        @(negedge clk_sys);
        check(name, rdata_q, exp);
    endtask

    task automatic stat(input logic [2:0] c, input logic to_n, pd_n, por_n);
        rd(ADDR_STAT, {26'h000_0000, c, por_n, pd_n, to_n}, "stat");
        check("to_n", timeout_flag_n_q, to_n);
        check("pd_n", powerdown_flag_n_q, pd_n);
    endtask

    // Counts whole cycles so delay figures can be judged afterwards
    task automatic wait_for(input logic lvl, input int max);
        hit = 1'b0;
        cnt = 0;
        while (!hit && cnt < max) begin
            @(negedge clk_sys);
            cnt++;
            hit = (core_hold_q === lvl);
        end
    endtask

    task automatic must(input logic lvl, input int max);
        wait_for(lvl, max);
        if (!hit) begin
            n_mismatch++;
            $display("[FAIL] core_hold_q expected %0d seen timeout", lvl);
            finish_test();
        end
    endtask

    task automatic irq_chk(input logic exp);
        repeat (2) @(negedge clk_sys);
        check("irq", irq_q, exp);
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        $display("[FAIL] run expected end seen timeout");
        finish_test();
    end

    initial begin
        rst = 1'b1;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        n_mismatch = 0;
        n_tests = 0;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        must(1'b0, 3000);
        rd(ADDR_CFG, 32'h0000_0007, "cfg");
        rd(8'h20, 32'h0000_0000, "unmapped");
        rd(ADDR_IRQ_CLR, 32'h0000_0000, "irq_clr");
        check("port_in", shared_port_input_q, 1'b0);
        stat(CAUSE_POR, 1'b1, 1'b1, 1'b0);
        wr(ADDR_IRQ_CLR, 32'h0000_007f);
        rd(ADDR_IRQ_ST, 32'h0000_0000, "irq_st");
        // Power-on with delay enabled and mid crystal
        wr(ADDR_STAT, 32'h0000_0004);
        wr(ADDR_CFG, 32'h0000_000e);
        rts_partner_i.hold_line(0, 10);
        must(1'b0, 3000);
        check("powerup_delay_timer_ost", 32'(cnt >= POWERUP_DELAY_TIMER_MIN + OST_MIN), 1);
        stat(CAUSE_POR, 1'b1, 1'b1, 1'b0);
        rd(ADDR_IRQ_ST, 32'h0000_0041, "irq_st");
        wr(ADDR_IRQ_CLR, 32'h0000_007f);
        // Brown-out: delay off, no oscillator count, core wait only
        wr(ADDR_CFG, 32'h0000_0007);
        wr(ADDR_STAT, 32'h0000_0004);
        rts_partner_i.hold_line(1, 10);
        must(1'b0, 3000);
        check("bor_fast", 32'(cnt < OST_MIN), 1);
        check("core_wait", 32'(cnt + 10 >= CORE_START_CYC - 2), 1);
        stat(CAUSE_BOR, 1'b1, 1'b1, 1'b1);
        // Watchdog reset while running, then interrupt masking
        wr(ADDR_IRQ_EN, 32'h0000_0008);
        rts_partner_i.hold_line(3, 1);
        must(1'b1, 20);
        check("regs_rst", regs_reset_q, 1'b1);
        must(1'b0, 3000);
        stat(CAUSE_WDT_RST, 1'b0, 1'b1, 1'b1);
        irq_chk(1'b1);
        wr(ADDR_IRQ_EN, 32'h0000_0000);
        irq_chk(1'b0);
        wr(ADDR_IRQ_EN, 32'h0000_0008);
        irq_chk(1'b1);
        wr(ADDR_IRQ_CLR, 32'h0000_0008);
        irq_chk(1'b0);
        // Watchdog wake leaves ordinary registers alone
        rts_partner_i.set_sleep(1'b1);
        rts_partner_i.hold_line(3, 1);
        must(1'b1, 20);
        check("regs_rst", regs_reset_q, 1'b0);
        must(1'b0, 3000);
        rts_partner_i.set_sleep(1'b0);
        stat(CAUSE_WDT_WAKE, 1'b0, 1'b0, 1'b1);
        // Short pin glitch is filtered out
        rts_partner_i.hold_line(2, 3);
        wait_for(1'b1, 30);
        check("glitch", hit, 1'b0);
        // Pin held past every delay releases promptly when it rises
        rts_partner_i.hold_line(2, 300);
        @(negedge clk_sys);
        check("pin_hold", core_hold_q, 1'b1);
        must(1'b0, 20);
        stat(CAUSE_PIN_RUN, 1'b0, 1'b0, 1'b1);
        rts_partner_i.set_sleep(1'b1);
        rts_partner_i.hold_line(2, 20);
        must(1'b0, 50);
        rts_partner_i.set_sleep(1'b0);
        stat(CAUSE_PIN_SLP, 1'b1, 1'b0, 1'b1);
        // Pin as plain input never resets the core
        wr(ADDR_CFG, 32'h0000_0003);
        fork
            rts_partner_i.hold_line(2, 30);
            begin
                repeat (15) @(negedge clk_sys);
                check("port_in", shared_port_input_q, 1'b0);
                wait_for(1'b1, 40);
            end
        join
        check("pin_masked", hit, 1'b0);
        check("port_in", shared_port_input_q, 1'b1);
        finish_test();
    end
endmodule // tb

`default_nettype wire
